// File: rtl/mpd_detector.sv
`timescale 1ns/10ps
`include "mpd_params.svh"

//Overview of operation
// [RQ1] writing one to baseline_capture latches the current X, Y, Z ambient as baseline
// [RQ2] once a baseline exists, deviation is reported; bigger disturbance gives bigger value
// [RQ3] axis_disable_mask bits 0, 1, 2 remove X, Y, Z from sensing
// [RQ4] comp_median_off set to one bypasses the compensation path median filter
// [RQ5] sense_median_off set to one bypasses the sensing path median filter
// [RQ6] smoothing_level 0 to 6 sets low-pass strength, 0 weakest, 6 strongest
// [RQ7] on_qualify_count 1..255 consecutive high samples needed to go on; 0 disables
// [RQ8] off_qualify_count 1..255 consecutive low samples needed to go off; 0 disables
// [RQ9] on when reading exceeds on_point, off only below on_point minus off_margin
// [RQ10] on_point and off_margin accept the full unsigned 16-bit range
// [RQ11] on_point resets to 150 and off_margin to 30, off point 120
// [RQ12] result LSB set while on, cleared once reading drops below off point
// [RQ13] drift tracking moves baseline toward ambient while readings stay under limit
// [RQ14] baseline tracking passes through a low-pass step set by drift_track_tau
// [RQ15] deviation_total combines the X, Y and Z deviations
// [RQ16] each axis deviation is the distance between baseline and current reading
// [RQ17] each axis baseline is readable in its own register
// [RQ18] each axis unfiltered reading is readable in its own register
// [RQ19] rate_change_limit sets a rate-of-change filter on the reported magnitude
// [RQ20] disabled axes add zero to the total, which saturates at 16-bit maximum
// [RQ21] capture is single-shot and completes before the next sample is processed
module mpd_detector
  import mpd_pkg::*;
#(
  parameter int AXES = 3,
  parameter int W    = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_smp_valid,
  input  wire mpd_xyz_t     i_smp,
  input  wire mpd_reg_req_t i_reg,
  output logic [15:0]       o_reg_rdata,
  output logic              o_reg_rvalid,
  output logic              o_present,
  output logic [15:0]       o_magnitude
);

  // configuration registers
  logic [15:0] axis_mask_r;
  logic [15:0] comp_med_off_r;
  logic [15:0] sense_med_off_r;
  logic [15:0] smoothing_r;
  logic [15:0] on_qual_r;
  logic [15:0] off_qual_r;
  logic [15:0] rate_limit_r;
  logic [15:0] on_point_r;
  logic [15:0] off_margin_r;
  logic [15:0] drift_time_r;
  logic [15:0] drift_limit_r;
  logic [15:0] drift_tau_r;

  // datapath state
  logic [AXES-1:0][W-1:0] raw_a;
  logic [AXES-1:0][W-1:0] unfilt_r;
  logic [AXES-1:0][W-1:0] sense_med;
  logic [AXES-1:0][W-1:0] comp_med;
  logic [AXES-1:0]        sense_vld;
  logic [AXES-1:0]        comp_vld;
  logic [AXES-1:0][W-1:0] filt_r;
  logic [AXES-1:0][W-1:0] comp_r;
  logic [AXES-1:0][W-1:0] base_r;
  logic [AXES-1:0][W-1:0] dev_r;
  logic                   have_base_r;
  logic [15:0]            total_r;
  logic [15:0]            total_nxt;
  logic [15:0]            mag_r;
  logic [15:0]            drift_cnt_r;
  logic                   drift_fire;
  logic                   vld2_r;
  logic                   vld3_r;
  logic                   vld4_r;
  logic                   capture_wr;
  mpd_pres_t              pres_r;
  logic [7:0]             hi_cnt_r;
  logic [7:0]             lo_cnt_r;
  logic [7:0]             hi_qual;
  logic [7:0]             lo_qual;
  logic [15:0]            off_pt;
  logic                   above;
  logic                   below;
  logic [3:0]             lvl;
  logic [3:0]             tau;
  logic [15:0]            mag_diff;
  logic [15:0]            rdata_nxt;

  // one low-pass step of cur toward tgt, shift 0 jumps straight to tgt
  function automatic logic [15:0] lp_step(input logic [15:0] cur,
                                          input logic [15:0] tgt,
                                          input logic [3:0]  sh);
    logic signed [16:0] d;
    logic signed [16:0] s;
    d = $signed({1'b0, tgt}) - $signed({1'b0, cur});
    s = d >>> sh;
    lp_step = 16'($signed({1'b0, cur}) + s);
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  assign raw_a      = i_smp;
  assign capture_wr = i_reg.wr && (i_reg.addr == `MPD_OFS_BASE_CAPTURE)
                      && i_reg.data[`MPD_BIT_CAPTURE];

  // register writes; capture is a trigger and is not stored
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      axis_mask_r     <= `MPD_RST_ZERO;
      comp_med_off_r  <= `MPD_RST_ZERO;
      sense_med_off_r <= `MPD_RST_ZERO;
      smoothing_r     <= `MPD_RST_ZERO;
      on_qual_r       <= `MPD_RST_ZERO;
      off_qual_r      <= `MPD_RST_ZERO;
      rate_limit_r    <= `MPD_RST_ZERO;
      on_point_r      <= `MPD_RST_ON_POINT;   // [RQ11]
      off_margin_r    <= `MPD_RST_OFF_MARGIN; // [RQ11]
      drift_time_r    <= `MPD_RST_ZERO;
      drift_limit_r   <= `MPD_RST_ZERO;
      drift_tau_r     <= `MPD_RST_ZERO;
    end else if (i_reg.wr) begin
      case (i_reg.addr)
        `MPD_OFS_AXIS_DISABLE:  axis_mask_r     <= i_reg.data;
        `MPD_OFS_COMP_MED_OFF:  comp_med_off_r  <= i_reg.data;
        `MPD_OFS_SENSE_MED_OFF: sense_med_off_r <= i_reg.data;
        `MPD_OFS_SMOOTHING:     smoothing_r     <= i_reg.data;
        `MPD_OFS_ON_QUALIFY:    on_qual_r       <= i_reg.data;
        `MPD_OFS_OFF_QUALIFY:   off_qual_r      <= i_reg.data;
        `MPD_OFS_RATE_LIMIT:    rate_limit_r    <= i_reg.data;
        `MPD_OFS_ON_POINT:      on_point_r      <= i_reg.data; // [RQ10]
        `MPD_OFS_OFF_MARGIN:    off_margin_r    <= i_reg.data; // [RQ10]
        `MPD_OFS_DRIFT_TIME:    drift_time_r    <= i_reg.data;
        `MPD_OFS_DRIFT_LIMIT:   drift_limit_r   <= i_reg.data;
        `MPD_OFS_DRIFT_TAU:     drift_tau_r     <= i_reg.data;
        default: ;
      endcase
    end
  end

  // out-of-range settings clamp to the strongest filter rather than wrapping
  assign lvl = (smoothing_r > 16'(`MPD_LVL_MAX)) ? `MPD_LVL_MAX : smoothing_r[3:0]; // [RQ6]
  assign tau = (drift_tau_r > 16'(`MPD_TAU_MAX)) ? `MPD_TAU_MAX : drift_tau_r[3:0];

  // per-axis capture, median filters and low-pass
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          unfilt_r[g] <= '0;
        end else if (i_smp_valid) begin
          unfilt_r[g] <= raw_a[g]; // [RQ18]
        end
      end

      mpd_median3 #(.W(W)) u_sense_med (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_valid  (i_smp_valid),
        .i_bypass (sense_med_off_r[`MPD_BIT_MED_OFF]), // [RQ5]
        .i_din    (raw_a[g]),
        .o_valid  (sense_vld[g]),
        .o_dout   (sense_med[g])
      );

      mpd_median3 #(.W(W)) u_comp_med (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_valid  (i_smp_valid),
        .i_bypass (comp_med_off_r[`MPD_BIT_MED_OFF]), // [RQ4]
        .i_din    (raw_a[g]),
        .o_valid  (comp_vld[g]),
        .o_dout   (comp_med[g])
      );

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          filt_r[g] <= '0;
          comp_r[g] <= '0;
        end else begin
          if (sense_vld[g]) begin
            filt_r[g] <= lp_step(filt_r[g], sense_med[g], lvl); // [RQ6]
          end
          if (comp_vld[g]) begin
            comp_r[g] <= comp_med[g];
          end
        end
      end

      // no baseline yet means nothing to deviate from
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          dev_r[g] <= '0;
        end else if (vld2_r) begin
          dev_r[g] <= have_base_r ? absdiff(filt_r[g], base_r[g]) : '0; // [RQ2] [RQ16]
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          base_r[g] <= '0;
        end else if (capture_wr) begin
          base_r[g] <= comp_r[g]; // [RQ1] [RQ21]
        end else if (drift_fire) begin
          base_r[g] <= lp_step(base_r[g], comp_r[g], tau); // [RQ13] [RQ14]
        end
      end
    end
  endgenerate

  // stage strobes; capture lands in the write cycle, ahead of any later sample
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vld2_r      <= 1'b0;
      vld3_r      <= 1'b0;
      vld4_r      <= 1'b0;
      have_base_r <= 1'b0;
    end else begin
      vld2_r <= sense_vld[0];
      vld3_r <= vld2_r;
      vld4_r <= vld3_r;
      if (capture_wr) begin
        have_base_r <= 1'b1; // [RQ1]
      end
    end
  end

  // saturating sum of the enabled axes
  always_comb begin
    logic [17:0] sum;
    sum = '0;
    for (int i = 0; i < AXES; i++) begin
      if (!axis_mask_r[i]) begin // [RQ3] [RQ20]
        sum = sum + 18'(dev_r[i]); // [RQ15]
      end
    end
    total_nxt = (sum > 18'(`MPD_SUM_MAX)) ? `MPD_SUM_MAX : sum[15:0]; // [RQ20]
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      total_r <= '0;
    end else if (vld3_r) begin
      total_r <= total_nxt; // [RQ15]
    end
  end

  // small moves below the rate limit are held back to suppress jitter
  assign mag_diff = absdiff(total_r, mag_r);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mag_r <= '0;
    end else if (vld4_r) begin
      if (rate_limit_r == '0 || mag_diff >= rate_limit_r) begin // [RQ19]
        mag_r <= total_r;
      end
    end
  end

  // drift tracking: one step per drift_track_time quiet samples, time 0 turns it off
  assign drift_fire = vld4_r && (drift_time_r != '0) && (total_r < drift_limit_r)
                      && (17'(drift_cnt_r) + 17'h00001 >= 17'(drift_time_r)) && !capture_wr;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      drift_cnt_r <= '0;
    end else if (capture_wr) begin
      drift_cnt_r <= '0;
    end else if (vld4_r) begin
      if (drift_time_r == '0 || total_r >= drift_limit_r || drift_fire) begin // [RQ13]
        drift_cnt_r <= '0;
      end else begin
        drift_cnt_r <= 16'(drift_cnt_r + 16'h0001);
      end
    end
  end

  // presence decision, evaluated once per reported magnitude
  assign off_pt  = (off_margin_r > on_point_r) ? '0 : 16'(on_point_r - off_margin_r);
  assign above   = mag_r > on_point_r; // [RQ9]
  assign below   = mag_r < off_pt;     // [RQ9]
  assign hi_qual = (on_qual_r[15:8] != '0) ? `MPD_QUAL_MAX : on_qual_r[7:0];
  assign lo_qual = (off_qual_r[15:8] != '0) ? `MPD_QUAL_MAX : off_qual_r[7:0];

  logic presence_pending;
  assign presence_pending = vld4_r;

  logic vld5_r;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vld5_r <= 1'b0;
    end else begin
      vld5_r <= presence_pending;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pres_r   <= MPD_OFF;
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else if (vld5_r) begin
      unique case (pres_r)
        MPD_OFF: begin
          lo_cnt_r <= '0;
          if (above) begin
            if (hi_qual == '0 || 9'(hi_cnt_r) + 9'h001 >= 9'(hi_qual)) begin // [RQ7]
              pres_r   <= MPD_ON;
              hi_cnt_r <= '0;
            end else begin
              hi_cnt_r <= 8'(hi_cnt_r + 8'h01);
            end
          end else begin
            hi_cnt_r <= '0; // [RQ7]
          end
        end
        MPD_ON: begin
          hi_cnt_r <= '0;
          if (below) begin
            if (lo_qual == '0 || 9'(lo_cnt_r) + 9'h001 >= 9'(lo_qual)) begin // [RQ8]
              pres_r   <= MPD_OFF;
              lo_cnt_r <= '0;
            end else begin
              lo_cnt_r <= 8'(lo_cnt_r + 8'h01);
            end
          end else begin
            lo_cnt_r <= '0; // [RQ8]
          end
        end
      endcase
    end
  end

  assign o_present   = (pres_r == MPD_ON); // [RQ12]
  assign o_magnitude = mag_r;

  // register reads; unmapped numbers and the capture trigger read as zero
  always_comb begin
    rdata_nxt = '0;
    case (i_reg.addr)
      `MPD_OFS_AXIS_DISABLE:  rdata_nxt = axis_mask_r;
      `MPD_OFS_COMP_MED_OFF:  rdata_nxt = comp_med_off_r;
      `MPD_OFS_SENSE_MED_OFF: rdata_nxt = sense_med_off_r;
      `MPD_OFS_SMOOTHING:     rdata_nxt = smoothing_r;
      `MPD_OFS_ON_QUALIFY:    rdata_nxt = on_qual_r;
      `MPD_OFS_OFF_QUALIFY:   rdata_nxt = off_qual_r;
      `MPD_OFS_RATE_LIMIT:    rdata_nxt = rate_limit_r;
      `MPD_OFS_ON_POINT:      rdata_nxt = on_point_r;
      `MPD_OFS_OFF_MARGIN:    rdata_nxt = off_margin_r;
      `MPD_OFS_DRIFT_TIME:    rdata_nxt = drift_time_r;
      `MPD_OFS_DRIFT_LIMIT:   rdata_nxt = drift_limit_r;
      `MPD_OFS_DRIFT_TAU:     rdata_nxt = drift_tau_r;
      `MPD_OFS_DETECT_RESULT: rdata_nxt = {15'h0000, o_present}; // [RQ12]
      `MPD_OFS_DEV_TOTAL:     rdata_nxt = total_r;   // [RQ15]
      `MPD_OFS_DEV_X:         rdata_nxt = dev_r[0];  // [RQ16]
      `MPD_OFS_DEV_Y:         rdata_nxt = dev_r[1];  // [RQ16]
      `MPD_OFS_DEV_Z:         rdata_nxt = dev_r[2];  // [RQ16]
      `MPD_OFS_AMBIENT_X:     rdata_nxt = base_r[0]; // [RQ17]
      `MPD_OFS_AMBIENT_Y:     rdata_nxt = base_r[1]; // [RQ17]
      `MPD_OFS_AMBIENT_Z:     rdata_nxt = base_r[2]; // [RQ17]
      `MPD_OFS_UNFILT_X:      rdata_nxt = unfilt_r[0]; // [RQ18]
      `MPD_OFS_UNFILT_Y:      rdata_nxt = unfilt_r[1]; // [RQ18]
      `MPD_OFS_UNFILT_Z:      rdata_nxt = unfilt_r[2]; // [RQ18]
      default:                rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg.rd;
      if (i_reg.rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

endmodule

// File: rtl/mpd_median3.sv
`timescale 1ns/10ps
module mpd_median3 #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_valid,
  input  wire logic         i_bypass,
  input  wire logic [W-1:0] i_din,
  output logic              o_valid,
  output logic [W-1:0]      o_dout
);

  logic [W-1:0] prev1_r;
  logic [W-1:0] prev2_r;
  logic [W-1:0] lo;
  logic [W-1:0] hi;
  logic [W-1:0] med;

  always_comb begin
    lo  = (i_din < prev1_r) ? i_din : prev1_r;
    hi  = (i_din < prev1_r) ? prev1_r : i_din;
    med = (hi < prev2_r) ? hi : prev2_r;
    med = (med > lo) ? med : lo;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prev1_r <= '0;
      prev2_r <= '0;
      o_dout  <= '0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        prev1_r <= i_din;
        prev2_r <= prev1_r;
        // history keeps filling while bypassed so re-enabling starts clean
        o_dout  <= i_bypass ? i_din : med;
      end
    end
  end

endmodule

// File: rtl/mpd_params.svh
`ifndef MPD_PARAMS_SVH
`define MPD_PARAMS_SVH

// register numbers, used directly as register addresses
`define MPD_OFS_BASE_CAPTURE   16'hadd5
`define MPD_OFS_AXIS_DISABLE   16'hadd6
`define MPD_OFS_COMP_MED_OFF   16'hadd7
`define MPD_OFS_SENSE_MED_OFF  16'hadd8
`define MPD_OFS_SMOOTHING      16'hadd9
`define MPD_OFS_ON_QUALIFY     16'hadda
`define MPD_OFS_OFF_QUALIFY    16'haddb
`define MPD_OFS_RATE_LIMIT     16'haddd
`define MPD_OFS_ON_POINT       16'hadde
`define MPD_OFS_OFF_MARGIN     16'haddf
`define MPD_OFS_DRIFT_TIME     16'hade0
`define MPD_OFS_DRIFT_LIMIT    16'hade1
`define MPD_OFS_DRIFT_TAU      16'hade2
`define MPD_OFS_DETECT_RESULT  16'hade8
`define MPD_OFS_DEV_TOTAL      16'hade9
`define MPD_OFS_DEV_X          16'hadea
`define MPD_OFS_DEV_Y          16'hadeb
`define MPD_OFS_DEV_Z          16'hadec
`define MPD_OFS_AMBIENT_X      16'haded
`define MPD_OFS_AMBIENT_Y      16'hadee
`define MPD_OFS_AMBIENT_Z      16'hadef
`define MPD_OFS_UNFILT_X       16'hadf0
`define MPD_OFS_UNFILT_Y       16'hadf1
`define MPD_OFS_UNFILT_Z       16'hadf2

// field positions
`define MPD_BIT_CAPTURE        0
`define MPD_BIT_MED_OFF        0
`define MPD_BIT_PRESENT        0

// reset values
`define MPD_RST_ZERO           16'h0000
`define MPD_RST_ON_POINT       16'h0096
`define MPD_RST_OFF_MARGIN     16'h001e

// filter limits
`define MPD_LVL_MAX            4'h6
`define MPD_TAU_MAX            4'hf
`define MPD_QUAL_MAX           8'hff
`define MPD_SUM_MAX            16'hffff

`endif

// File: rtl/mpd_pkg.sv
package mpd_pkg;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } mpd_xyz_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] data;
  } mpd_reg_req_t;

  typedef enum logic {
    MPD_OFF = 1'b0,
    MPD_ON  = 1'b1
  } mpd_pres_t;

endpackage

// File: verif/mpd_detector_sva.sv
`timescale 1ns/10ps
`include "mpd_params.svh"
module mpd_detector_sva
  import mpd_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_resetn,
  input wire logic         i_smp_valid,
  input wire mpd_xyz_t     i_smp,
  input wire mpd_reg_req_t i_reg,
  input wire logic [15:0]  o_reg_rdata,
  input wire logic         o_reg_rvalid,
  input wire logic         o_present,
  input wire logic [15:0]  o_magnitude
);
  logic [15:0] on_pt_r;
  logic [15:0] off_m_r;
  logic [15:0] off_pt;

  // shadows of the threshold pair so switching points are judged here
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      on_pt_r <= `MPD_RST_ON_POINT;
    end else if (i_reg.wr && i_reg.addr == `MPD_OFS_ON_POINT) begin
      on_pt_r <= i_reg.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      off_m_r <= `MPD_RST_OFF_MARGIN;
    end else if (i_reg.wr && i_reg.addr == `MPD_OFS_OFF_MARGIN) begin
      off_m_r <= i_reg.data;
    end
  end

  assign off_pt = (off_m_r > on_pt_r) ? 16'h0000 : on_pt_r - off_m_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_read_answer: assert property (i_reg.rd |=> o_reg_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg.rd))
    else $error("read valid without a read");
  chk_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  // magnitude lands five edges after the sample edge, presence one edge later
  chk_mag_timing: assert property ($changed(o_magnitude) |-> $past(i_smp_valid, 5))
    else $error("magnitude moved off the sample pipeline");
  chk_pres_timing: assert property ($changed(o_present) |-> $past(i_smp_valid, 6))
    else $error("presence moved off the sample pipeline");
  chk_pres_rise: assert property ($rose(o_present) |-> o_magnitude > on_pt_r)
    else $error("presence rose at or below the on point");
  chk_pres_fall: assert property ($fell(o_present) |-> o_magnitude < off_pt)
    else $error("presence fell above the off point");
  chk_onpt_read: assert property (o_reg_rvalid
    && $past(i_reg.addr) == `MPD_OFS_ON_POINT |-> o_reg_rdata == $past(on_pt_r))
    else $error("on point readback wrong");
  chk_trig_read: assert property (o_reg_rvalid
    && $past(i_reg.addr) == `MPD_OFS_BASE_CAPTURE |-> o_reg_rdata == 16'h0000)
    else $error("capture trigger reads nonzero");
  chk_result_read: assert property (o_reg_rvalid
    && $past(i_reg.addr) == `MPD_OFS_DETECT_RESULT
    |-> o_reg_rdata == {15'h0000, $past(o_present)})
    else $error("result register disagrees with presence");
endmodule

bind mpd_detector mpd_detector_sva mpd_detector_sva_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_smp_valid(i_smp_valid), .i_smp(i_smp),
  .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_present(o_present), .o_magnitude(o_magnitude)
);

// File: verif/mpd_field_sensor.sv
`timescale 1ns/10ps
module mpd_field_sensor
  import mpd_pkg::*;
#(
  parameter int PERIOD = 12
) (
  input  wire logic     i_clk,
  input  wire logic     i_resetn,
  input  wire mpd_xyz_t i_field,
  output logic          o_smp_valid,
  output mpd_xyz_t      o_smp
);
  logic [7:0] tick_r;
  logic       due;

  assign due = (tick_r == 8'(PERIOD - 1));

  always_ff @(posedge i_clk) begin
    if (!i_resetn || due) begin
      tick_r <= 8'h00;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end

  // between samples the bus carries the inverse, so a stray read is never right by luck
  always_ff @(posedge i_clk) begin
    o_smp_valid <= i_resetn && due;
    o_smp       <= due ? i_field : ~i_field;
  end
endmodule

// File: verif/tb_magnetic_presence_detector.sv
`timescale 1ns/10ps
`include "mpd_params.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end
module tb_magnetic_presence_detector
  import mpd_pkg::*;
;
  localparam logic [15:0] BASE = 16'h7530;
  logic         i_clk;
  logic         i_resetn;
  logic         smp_valid;
  mpd_xyz_t     smp;
  mpd_xyz_t     field;
  mpd_reg_req_t reg_q;
  logic [15:0]  rdata;
  logic         rvalid;
  logic         present;
  logic [15:0]  magnitude;
  logic [15:0]  rd_q;
  int           err_total;
  int           num_checks;

  mpd_field_sensor #(.PERIOD(12)) mpd_field_sensor_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_field(field), .o_smp_valid(smp_valid), .o_smp(smp));
  mpd_detector mpd_detector_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_smp_valid(smp_valid),
    .i_smp(smp), .i_reg(reg_q), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_present(present), .o_magnitude(magnitude));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_total++;
    $display("MISMATCH wait exp=done got=timeout");
    close_out();
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    reg_q <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge i_clk);
    reg_q <= '0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] e);
    int n;
    @(posedge i_clk);
    reg_q <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
    @(posedge i_clk);
    reg_q <= '0;
    n = 0;
    #1;
    while (rvalid !== 1'b1) begin
      n++;
      if (n > 4) timed_out();
      @(posedge i_clk);
      #1;
    end
    `CHK(nm, e, rdata)
  endtask

  // returns once the last counted sample has reached the presence output
  task automatic wait_smp(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge i_clk);
        #1;
        k++;
        if (k > 40) timed_out();
      end while (smp_valid !== 1'b1);
    end
    repeat (8) @(posedge i_clk);
    #1;
  endtask

  task automatic set_offs(input logic [15:0] dx, input logic [15:0] dy, input logic [15:0] dz);
    @(posedge i_clk);
    field <= '{z: BASE + dz, y: BASE + dy, x: BASE + dx};
  endtask

  task automatic t_regs();
    logic [15:0] v;
    rd_chk("on_point", `MPD_OFS_ON_POINT, 16'h0096);
    rd_chk("off_margin", `MPD_OFS_OFF_MARGIN, 16'h001e);
    rd_chk("on_qualify", `MPD_OFS_ON_QUALIFY, 16'h0000);
    rd_chk("off_qualify", `MPD_OFS_OFF_QUALIFY, 16'h0000);
    rd_chk("capture", `MPD_OFS_BASE_CAPTURE, 16'h0000);
    reg_wr(`MPD_OFS_DEV_X, 16'h1234);
    rd_chk("dev_x_ro", `MPD_OFS_DEV_X, 16'h0000);
    rd_chk("unmapped", 16'hadd4, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      v = i[0] ? 16'h0000 : 16'hffff;
      reg_wr(`MPD_OFS_ON_POINT, v);
      reg_wr(`MPD_OFS_OFF_MARGIN, ~v);
      rd_chk("on_point", `MPD_OFS_ON_POINT, v);
      rd_chk("off_margin", `MPD_OFS_OFF_MARGIN, ~v);
    end
    reg_wr(`MPD_OFS_ON_POINT, 16'h0096);
    reg_wr(`MPD_OFS_OFF_MARGIN, 16'h001e);
  endtask

  task automatic t_capture();
    wait_smp(4);
    rd_chk("raw_x", `MPD_OFS_UNFILT_X, BASE);
    rd_chk("raw_z", `MPD_OFS_UNFILT_Z, BASE);
    rd_chk("dev_x", `MPD_OFS_DEV_X, 16'h0000);
    reg_wr(`MPD_OFS_BASE_CAPTURE, 16'h0001);
    rd_chk("amb_x", `MPD_OFS_AMBIENT_X, BASE);
    rd_chk("amb_y", `MPD_OFS_AMBIENT_Y, BASE);
    set_offs(16'h0064, 16'h0032, 16'hffd8);
    wait_smp(4);
    rd_chk("raw_y", `MPD_OFS_UNFILT_Y, BASE + 16'h0032);
    rd_chk("dev_x", `MPD_OFS_DEV_X, 16'h0064);
    rd_chk("dev_y", `MPD_OFS_DEV_Y, 16'h0032);
    rd_chk("dev_z", `MPD_OFS_DEV_Z, 16'h0028);
    rd_chk("total", `MPD_OFS_DEV_TOTAL, 16'h00be);
    `CHK("magnitude", 16'h00be, magnitude)
    rd_chk("result", `MPD_OFS_DETECT_RESULT, 16'h0001);
  endtask

  task automatic t_hyst_axes();
    logic [15:0] hx[4] = '{16'h0082, 16'h006e, 16'h008c, 16'h00a0};
    logic        hp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      set_offs(hx[i], 16'h0000, 16'h0000);
      wait_smp(3);
      `CHK("present", hp[i], present)
    end
    set_offs(16'h0064, 16'h00c8, 16'h0190);
    wait_smp(3);
    for (int m = 0; m < 8; m++) begin
      reg_wr(`MPD_OFS_AXIS_DISABLE, 16'(m));
      wait_smp(1);
      rd_chk("total", `MPD_OFS_DEV_TOTAL, (m[0] ? 16'h0000 : 16'h0064) +
        (m[1] ? 16'h0000 : 16'h00c8) + (m[2] ? 16'h0000 : 16'h0190));
    end
    reg_wr(`MPD_OFS_AXIS_DISABLE, 16'h0000);
    set_offs(16'h7530, 16'h7530, 16'h7530);
    wait_smp(3);
    rd_chk("total_sat", `MPD_OFS_DEV_TOTAL, 16'hffff);
  endtask

  task automatic t_qualify();
    reg_wr(`MPD_OFS_COMP_MED_OFF, 16'h0001);
    reg_wr(`MPD_OFS_SENSE_MED_OFF, 16'h0001);
    reg_wr(`MPD_OFS_ON_QUALIFY, 16'h0003);
    set_offs(16'h0000, 16'h0000, 16'h0000);
    wait_smp(2);
    set_offs(16'h00c8, 16'h0000, 16'h0000);
    wait_smp(1);
    `CHK("magnitude", 16'h00c8, magnitude)
    `CHK("present", 1'b0, present)
    wait_smp(1);
    `CHK("present", 1'b0, present)
    wait_smp(1);
    `CHK("present", 1'b1, present)
    reg_wr(`MPD_OFS_OFF_QUALIFY, 16'h0002);
    set_offs(16'h0000, 16'h0000, 16'h0000);
    wait_smp(1);
    `CHK("present", 1'b1, present)
    wait_smp(1);
    `CHK("present", 1'b0, present)
    reg_wr(`MPD_OFS_ON_QUALIFY, 16'h0000);
    reg_wr(`MPD_OFS_OFF_QUALIFY, 16'h0000);
  endtask

  task automatic t_filters();
    for (int l = 0; l < 7; l++) begin
      reg_wr(`MPD_OFS_SMOOTHING, 16'h0000);
      set_offs(16'h0000, 16'h0000, 16'h0000);
      wait_smp(1);
      reg_wr(`MPD_OFS_SMOOTHING, 16'(l));
      set_offs(16'h0100, 16'h0000, 16'h0000);
      wait_smp(1);
      `CHK("smoothed", 16'h0100 >> l, magnitude)
    end
    reg_wr(`MPD_OFS_SMOOTHING, 16'h0000);
    set_offs(16'h0000, 16'h0000, 16'h0000);
    wait_smp(1);
    reg_wr(`MPD_OFS_RATE_LIMIT, 16'h0032);
    set_offs(16'h001e, 16'h0000, 16'h0000);
    wait_smp(1);
    `CHK("delta_hold", 16'h0000, magnitude)
    set_offs(16'h0050, 16'h0000, 16'h0000);
    wait_smp(1);
    `CHK("delta_pass", 16'h0050, magnitude)
    reg_wr(`MPD_OFS_DRIFT_LIMIT, 16'h03e8);
    reg_wr(`MPD_OFS_DRIFT_TAU, 16'h0000);
    // a sample may slip in uncounted after the write, so at most two quiet samples precede the check
    reg_wr(`MPD_OFS_DRIFT_TIME, 16'h0003);
    wait_smp(1);
    rd_chk("amb_x", `MPD_OFS_AMBIENT_X, BASE);
    wait_smp(3);
    rd_chk("amb_x", `MPD_OFS_AMBIENT_X, BASE + 16'h0050);
  endtask

  task automatic t_reset();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd_chk("amb_x_rst", `MPD_OFS_AMBIENT_X, 16'h0000);
    rd_chk("on_pt_rst", `MPD_OFS_ON_POINT, 16'h0096);
    rd_chk("rate_rst", `MPD_OFS_RATE_LIMIT, 16'h0000);
    `CHK("mag_rst", 16'h0000, magnitude)
  endtask

  initial begin
    err_total = 0;
    num_checks = 0;
    i_resetn = 1'b0;
    reg_q = '0;
    field = '{z: BASE, y: BASE, x: BASE};
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_capture();
    t_hyst_axes();
    t_qualify();
    t_filters();
    t_reset();
    close_out();
  end
endmodule
